// [logic/clk_synth_map.svh]
// Register map, bus addresses and timing constants of the clock synthesizer SMBus link
// Function
// - Block write: index, count, then data bytes
// - Device acknowledges each data byte, stores only up to the count
// - Write address d2, read address d3
// - Block read: index, repeated start, read address
// - Device sends count, then registers from index
// - Host acks all but last, then stops
// - Read length equals readback count, reset ten
// - Byte 0 enables differential outputs, reset one
// - Byte 1 bit 7 enables reference output
// - Byte 1 bit 0 enables down spread
// - Byte 2 enables single-ended outputs
// - Byte 5 five-bit margin select, reset 01111
// - Byte 6 four-bit frequency select, reset 1000
// - Byte 7 read-only revision and maker codes
// - Byte 9 read-only part code
// - Byte 10 bit 7 enables divider programming
// - N and M divider bits in bytes 11, 12
// - VCO is 25 times (N+8) over (M+2)
`ifndef CLK_SYNTH_MAP_SVH
`define CLK_SYNTH_MAP_SVH

// ----------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------
`define ADDR_WR         8'hd2
`define ADDR_RD         8'hd3

// ----------------------------------------------------------------
// Register indices, reset values, writable masks
// ----------------------------------------------------------------
`define NREG            8'd13
`define REG_DIFF_EN     4'h0
`define REG_REF_SPREAD  4'h1
`define REG_SE_EN       4'h2
`define REG_RSVD_A      4'h3
`define REG_RSVD_B      4'h4
`define REG_MARGIN      4'h5
`define REG_FREQ        4'h6
`define REG_REVISION    4'h7
`define REG_COUNT       4'h8
`define REG_PART        4'h9
`define REG_DIV_CTRL    4'ha
`define REG_DIV_HIGH    4'hb
`define REG_DIV_LOW     4'hc
`define RST_DIFF_EN     8'hff
`define RST_REF_SPREAD  8'h9e
`define RST_SE_EN       8'h3f
`define RST_MARGIN      8'h0f
`define RST_FREQ        8'h08
`define RST_COUNT       8'h0a
`define RST_DIV_CTRL    8'h00
`define RST_DIV_HIGH    8'h0a
`define RST_DIV_LOW     8'h28
`define WM_DIFF_EN      8'hd7
`define WM_REF_SPREAD   8'h81
`define WM_SE_EN        8'h3f
`define WM_MARGIN       8'h1f
`define WM_FREQ         8'h0f
`define WM_DIV_CTRL     8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_DISPLAY_EN  7
`define BIT_NS1_EN      6
`define BIT_NS0_EN      4
`define BIT_REF_EN      7
`define BIT_SPREAD_EN   0
`define BIT_USB48_EN    0
`define BIT_DIV_PROG    7
`define BIT_N9          6
`define BIT_N8          7

// ----------------------------------------------------------------
// VCO arithmetic and link timing
// ----------------------------------------------------------------
`define VCO_REF_MHZ     15'd25
`define VCO_N_OFS       15'd8
`define VCO_M_OFS       7'd2
`define CLK_NS          10
`define SCL_PERIOD_NS   5000
`define SCL_QTR_CYC     ((`SCL_PERIOD_NS / 4) / `CLK_NS)

`endif

// [logic/clk_synth_pkg.sv]
// Shared types of the clock synthesizer SMBus link
`default_nettype none
package clk_synth_pkg;
	typedef enum logic [2:0] {
		D_IDLE   = 3'b000,
		D_RX     = 3'b001,
		D_RX_ACK = 3'b011,
		D_TX     = 3'b010,
		D_TX_ACK = 3'b110
	} dev_state_e;
	typedef enum logic [1:0] {R_ADDR, R_INDEX, R_COUNT, R_DATA} dev_role_e;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_START = 3'b001,
		H_TX    = 3'b011,
		H_RX    = 3'b010,
		H_STOP  = 3'b110
	} host_state_e;
	typedef enum logic [2:0] {
		HR_ADDR_W, HR_INDEX, HR_COUNT, HR_WDATA, HR_ADDR_R, HR_RCOUNT, HR_RDATA
	} host_role_e;
endpackage : clk_synth_pkg
`default_nettype wire

// [logic/smbus_link_if.sv]
// Open-drain SMBus link between host and clock synthesizer
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// Pull-ups win unless an enabled driver holds the line low
	assign scl = ~(scl_host_oe & ~scl_host_o);
	assign sda = ~(sda_host_oe & ~sda_host_o) & ~(sda_dev_oe & ~sda_dev_o);

	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
		output sda_host_o, output sda_host_oe);
endinterface : smbus_link_if
`default_nettype wire

// [logic/smbus_target.sv]
// Clock synthesizer SMBus target with its control register file
//
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_map.svh"
module smbus_target
	import clk_synth_pkg::*;
#(
	parameter logic [3:0] REV_CODE   = 4'h5,  // Arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'ha,  // Arbitrary value
	parameter logic [7:0] PART_CODE  = 8'h5c  // Arbitrary value
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	smbus_link_if.device     link,
	output logic             display_clock_96m_en_o,
	output logic [1:0]       nonspread_storage_clock_en_o,
	output logic [2:0]       serdes_ref_clock_en_o,
	output logic             reference_14m_output_en_o,
	output logic             spread_en_o,
	output logic [4:0]       pci_en_o,
	output logic             usb48_en_o,
	output logic [4:0]       margin_sel_o,
	output logic [3:0]       main_freq_sel_o,
	output logic             divider_prog_en_o,
	output logic [14:0]      vco_mult_o,
	output logic [6:0]       vco_div_o
);

	// ----------------------------------------------------------------
	// Register attributes
	// ----------------------------------------------------------------
	function automatic logic [7:0] wmask(input logic [3:0] i);
		case (i)
			`REG_DIFF_EN:    wmask = `WM_DIFF_EN;
			`REG_REF_SPREAD: wmask = `WM_REF_SPREAD;
			`REG_SE_EN:      wmask = `WM_SE_EN;
			`REG_MARGIN:     wmask = `WM_MARGIN;
			`REG_FREQ:       wmask = `WM_FREQ;
			`REG_COUNT:      wmask = 8'hff;
			`REG_DIV_CTRL:   wmask = `WM_DIV_CTRL;
			`REG_DIV_HIGH:   wmask = 8'hff;
			`REG_DIV_LOW:    wmask = 8'hff;
			default:         wmask = 8'h00;
		endcase
	endfunction : wmask

	function automatic logic [7:0] rstv(input logic [3:0] i);
		case (i)
			`REG_DIFF_EN:    rstv = `RST_DIFF_EN;
			`REG_REF_SPREAD: rstv = `RST_REF_SPREAD;
			`REG_SE_EN:      rstv = `RST_SE_EN;
			`REG_MARGIN:     rstv = `RST_MARGIN;
			`REG_FREQ:       rstv = `RST_FREQ;
			`REG_COUNT:      rstv = `RST_COUNT;
			`REG_DIV_CTRL:   rstv = `RST_DIV_CTRL;
			`REG_DIV_HIGH:   rstv = `RST_DIV_HIGH;
			`REG_DIV_LOW:    rstv = `RST_DIV_LOW;
			default:         rstv = 8'h00;
		endcase
	endfunction : rstv

	// ----------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------------------------------
	logic       scl_m_r, scl_s_r, scl_d_r;
	logic       sda_m_r, sda_s_r, sda_d_r;
	logic       scl_rise, scl_fall, start_c, stop_c;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
		end else begin
			scl_m_r <= link.scl;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= link.sda;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ----------------------------------------------------------------
	// Register storage and read path
	// ----------------------------------------------------------------
	dev_state_e st_r;
	dev_role_e  role_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, txb_r, idx_r, left_r;
	logic       rd_r, low_r, hack_r;
	logic [7:0] regs_r [0:12];
	logic [7:0] rd_val;
	logic       wr_stb;

	always_comb begin
		rd_val = 8'h00;
		if (idx_r == 8'(`REG_REVISION))
			rd_val = {REV_CODE, MAKER_CODE};
		else if (idx_r == 8'(`REG_PART))
			rd_val = PART_CODE;
		else if (idx_r < `NREG)
			rd_val = (regs_r[idx_r[3:0]] & wmask(idx_r[3:0]))
				| (rstv(idx_r[3:0]) & ~wmask(idx_r[3:0]));
	end

	// A byte past the announced count is acknowledged but not stored
	assign wr_stb = (st_r == D_RX) && scl_fall && (cnt_r == 4'h8) && (role_r == R_DATA)
		&& (left_r != 8'h00) && !start_c && !stop_c;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 13; i++) begin
				regs_r[i] <= rstv(4'(i)) & wmask(4'(i));
			end
		end else if (wr_stb && idx_r < `NREG) begin
			regs_r[idx_r[3:0]] <= sh_r & wmask(idx_r[3:0]);
		end
	end

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r   <= D_IDLE;
			role_r <= R_ADDR;
			cnt_r  <= 4'h0;
			sh_r   <= 8'h00;
			txb_r  <= 8'h00;
			idx_r  <= 8'h00;
			left_r <= 8'h00;
			rd_r   <= 1'b0;
			low_r  <= 1'b0;
			hack_r <= 1'b0;
		end else if (stop_c) begin
			st_r  <= D_IDLE;
			low_r <= 1'b0;
		end else if (start_c) begin
			// Index survives a repeated start so a read follows the index write
			st_r   <= D_RX;
			role_r <= R_ADDR;
			cnt_r  <= 4'h0;
			low_r  <= 1'b0;
		end else begin
			case (st_r)
				D_RX: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], sda_s_r};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_r <= 4'h0;
						low_r <= 1'b1;
						st_r  <= D_RX_ACK;
						case (role_r)
							R_ADDR: begin
								if (sh_r == `ADDR_WR) begin
									rd_r   <= 1'b0;
									role_r <= R_INDEX;
								end else if (sh_r == `ADDR_RD) begin
									rd_r   <= 1'b1;
									txb_r  <= regs_r[`REG_COUNT];
									left_r <= regs_r[`REG_COUNT];
								end else begin
									low_r <= 1'b0;
									st_r  <= D_IDLE;
								end
							end
							R_INDEX: begin
								idx_r  <= sh_r;
								role_r <= R_COUNT;
							end
							R_COUNT: begin
								left_r <= sh_r;
								role_r <= R_DATA;
							end
							default: begin
								if (left_r != 8'h00) begin
									idx_r  <= idx_r + 8'h01;
									left_r <= left_r - 8'h01;
								end
							end
						endcase
					end
				end
				D_RX_ACK: begin
					if (scl_fall) begin
						if (rd_r) begin
							low_r <= ~txb_r[7];
							txb_r <= {txb_r[6:0], 1'b0};
							cnt_r <= 4'h1;
							st_r  <= D_TX;
						end else begin
							low_r <= 1'b0;
							st_r  <= D_RX;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							low_r <= 1'b0;
							st_r  <= D_TX_ACK;
						end else begin
							low_r <= ~txb_r[7];
							txb_r <= {txb_r[6:0], 1'b0};
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				D_TX_ACK: begin
					if (scl_rise) begin
						hack_r <= ~sda_s_r;
					end else if (scl_fall) begin
						// Sending stops at the count even if the host keeps acking
						if (hack_r && left_r != 8'h00) begin
							low_r  <= ~rd_val[7];
							txb_r  <= {rd_val[6:0], 1'b0};
							idx_r  <= idx_r + 8'h01;
							left_r <= left_r - 8'h01;
							cnt_r  <= 4'h1;
							st_r   <= D_TX;
						end else begin
							st_r <= D_IDLE;
						end
					end
				end
				default: st_r <= D_IDLE;
			endcase
		end
	end

	assign link.sda_dev_o  = 1'b0;
	assign link.sda_dev_oe = low_r;

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	logic [9:0] n_sel;
	logic [5:0] m_sel;

	localparam logic [7:0] DIV_HIGH_DEF = `RST_DIV_HIGH;
	localparam logic [7:0] DIV_LOW_DEF  = `RST_DIV_LOW;

	always_comb begin
		n_sel = {DIV_HIGH_DEF[`BIT_N9], DIV_HIGH_DEF[`BIT_N8], DIV_LOW_DEF};
		m_sel = DIV_HIGH_DEF[5:0];
		if (regs_r[`REG_DIV_CTRL][`BIT_DIV_PROG]) begin
			n_sel = {regs_r[`REG_DIV_HIGH][`BIT_N9], regs_r[`REG_DIV_HIGH][`BIT_N8],
				regs_r[`REG_DIV_LOW]};
			m_sel = regs_r[`REG_DIV_HIGH][5:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			display_clock_96m_en_o       <= 1'b1;
			nonspread_storage_clock_en_o <= 2'b11;
			serdes_ref_clock_en_o        <= 3'b111;
			reference_14m_output_en_o    <= 1'b1;
			spread_en_o                  <= 1'b0;
			pci_en_o                     <= 5'h1f;
			usb48_en_o                   <= 1'b1;
			margin_sel_o                 <= 5'h0f;
			main_freq_sel_o              <= 4'h8;
			divider_prog_en_o            <= 1'b0;
			vco_mult_o                   <= 15'h0000;
			vco_div_o                    <= 7'h00;
		end else begin
			display_clock_96m_en_o       <= regs_r[`REG_DIFF_EN][`BIT_DISPLAY_EN];
			nonspread_storage_clock_en_o <= {regs_r[`REG_DIFF_EN][`BIT_NS1_EN],
				regs_r[`REG_DIFF_EN][`BIT_NS0_EN]};
			serdes_ref_clock_en_o        <= regs_r[`REG_DIFF_EN][2:0];
			reference_14m_output_en_o    <= regs_r[`REG_REF_SPREAD][`BIT_REF_EN];
			spread_en_o                  <= regs_r[`REG_REF_SPREAD][`BIT_SPREAD_EN];
			pci_en_o                     <= regs_r[`REG_SE_EN][5:1];
			usb48_en_o                   <= regs_r[`REG_SE_EN][`BIT_USB48_EN];
			margin_sel_o                 <= regs_r[`REG_MARGIN][4:0];
			main_freq_sel_o              <= regs_r[`REG_FREQ][3:0];
			divider_prog_en_o            <= regs_r[`REG_DIV_CTRL][`BIT_DIV_PROG];
			vco_mult_o <= `VCO_REF_MHZ * (15'(n_sel) + `VCO_N_OFS);
			vco_div_o  <= 7'(m_sel) + `VCO_M_OFS;
		end
	end

endmodule : smbus_target
`default_nettype wire

// [logic/smbus_host.sv]
// SMBus host that runs indexed block writes and reads to the clock synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_map.svh"
module smbus_host
	import clk_synth_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	smbus_link_if.host       link,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic        cmd_read_i,
	input  wire logic [7:0]  cmd_index_i,
	input  wire logic [7:0]  cmd_count_i,
	output logic             wr_req_o,
	input  wire logic [7:0]  wr_data_i,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	output logic [7:0]       rd_len_o,
	output logic             done_o,
	output logic             nack_o
);
	localparam int QTR = `SCL_QTR_CYC;

	host_state_e st_r;
	host_role_e  role_r;
	logic [9:0]  q_cnt_r;
	logic [1:0]  q_r;
	logic [3:0]  bit_r;
	logic [7:0]  sh_r, idx_r, left_r;
	logic        rd_r, bad_r, tick, nack_bit;
	logic        sda_m_r, sda_s_r;
	logic        scl_v, sda_v;

	// ----------------------------------------------------------------
	// Quarter-bit timing and data sampling
	// ----------------------------------------------------------------
	assign tick        = (q_cnt_r == 10'(QTR - 1));
	assign cmd_ready_o = (st_r == H_IDLE);
	// Last byte of a read is refused so the target lets go of the line
	assign nack_bit = (role_r == HR_RCOUNT) ? (sh_r == 8'h00) : (left_r == 8'h01);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end else begin
			sda_m_r <= link.sda;
			sda_s_r <= sda_m_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || st_r == H_IDLE || tick) begin
			q_cnt_r <= 10'h000;
		end else begin
			q_cnt_r <= q_cnt_r + 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		wr_req_o   <= 1'b0;
		rd_valid_o <= 1'b0;
		done_o     <= 1'b0;
		if (rst_i) begin
			st_r      <= H_IDLE;
			role_r    <= HR_ADDR_W;
			q_r       <= 2'b00;
			bit_r     <= 4'h0;
			sh_r      <= 8'h00;
			idx_r     <= 8'h00;
			left_r    <= 8'h00;
			rd_r      <= 1'b0;
			bad_r     <= 1'b0;
			rd_data_o <= 8'h00;
			rd_len_o  <= 8'h00;
			nack_o    <= 1'b0;
		end else if (st_r == H_IDLE) begin
			if (cmd_valid_i) begin
				st_r   <= H_START;
				role_r <= HR_ADDR_W;
				bit_r  <= 4'h9;
				sh_r   <= `ADDR_WR;
				idx_r  <= cmd_index_i;
				left_r <= cmd_count_i;
				rd_r   <= cmd_read_i;
				q_r    <= 2'b00;
				nack_o <= 1'b0;
			end
		end else if (tick) begin
			q_r <= q_r + 2'b01;
			if (q_r == 2'b10) begin
				if (st_r == H_TX && bit_r == 4'h8)
					bad_r <= sda_s_r;
				else if (st_r == H_RX && bit_r != 4'h8)
					sh_r <= {sh_r[6:0], sda_s_r};
			end
			if (q_r == 2'b11) begin
				bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
				case (st_r)
					H_START: begin
						st_r  <= H_TX;
						bit_r <= 4'h0;
					end
					H_TX: begin
						if (bit_r == 4'h8) begin
							if (bad_r) begin
								nack_o <= 1'b1;
								st_r   <= H_STOP;
							end else begin
								case (role_r)
									HR_ADDR_W: begin
										sh_r   <= idx_r;
										role_r <= HR_INDEX;
									end
									HR_INDEX: begin
										if (rd_r) begin
											st_r   <= H_START;
											sh_r   <= `ADDR_RD;
											role_r <= HR_ADDR_R;
										end else begin
											sh_r   <= left_r;
											role_r <= HR_COUNT;
										end
									end
									HR_ADDR_R: begin
										st_r   <= H_RX;
										role_r <= HR_RCOUNT;
									end
									default: begin
										if (role_r == HR_WDATA)
											left_r <= left_r - 8'h01;
										if (left_r == 8'h00 || (role_r == HR_WDATA && left_r == 8'h01)) begin
											st_r <= H_STOP;
										end else begin
											sh_r     <= wr_data_i;
											wr_req_o <= 1'b1;
											role_r   <= HR_WDATA;
										end
									end
								endcase
							end
						end
					end
					H_RX: begin
						if (bit_r == 4'h8) begin
							if (role_r == HR_RCOUNT) begin
								rd_len_o <= sh_r;
								left_r   <= sh_r;
								role_r   <= HR_RDATA;
								if (sh_r == 8'h00)
									st_r <= H_STOP;
							end else begin
								rd_data_o  <= sh_r;
								rd_valid_o <= 1'b1;
								left_r     <= left_r - 8'h01;
								if (left_r == 8'h01)
									st_r <= H_STOP;
							end
						end
					end
					H_STOP: begin
						st_r   <= H_IDLE;
						done_o <= 1'b1;
					end
					default: st_r <= H_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Line levels per quarter
	// ----------------------------------------------------------------
	always_comb begin
		scl_v = q_r[0] ^ q_r[1];
		sda_v = 1'b1;
		case (st_r)
			H_IDLE: scl_v = 1'b1;
			H_START: begin
				// From an idle bus the clock stays high, no short low pulse
				if (bit_r == 4'h9)
					scl_v = ~(q_r[0] & q_r[1]);
				sda_v = ~q_r[1];
			end
			H_TX: sda_v = (bit_r == 4'h8) ? 1'b1 : sh_r[3'(4'h7 - bit_r)];
			H_RX: sda_v = (bit_r == 4'h8) ? nack_bit : 1'b1;
			H_STOP: begin
				scl_v = q_r[0] | q_r[1];
				sda_v = q_r[1];
			end
			default: scl_v = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.scl_host_oe <= 1'b0;
			link.sda_host_oe <= 1'b0;
		end else begin
			link.scl_host_oe <= ~scl_v;
			link.sda_host_oe <= ~sda_v;
		end
	end

	assign link.scl_host_o = 1'b0;
	assign link.sda_host_o = 1'b0;

endmodule : smbus_host
`default_nettype wire

// [bench/smbus_link_assertions.sv]
// Protocol checker watching the open-drain SMBus link between host and target
`timescale 1ns/1ps
`default_nettype none
module smbus_link_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_host_o,
	input wire logic scl_host_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------------------------------
	// Phase counters
	// ----------------------------------------------------------------
	int hi_cnt;
	int lo_cnt;
	int dev_cnt;

	always_ff @(posedge clk_i) begin
		hi_cnt <= (rst_i || !scl) ? 0 : hi_cnt + 1;
		lo_cnt <= (rst_i || scl) ? 0 : lo_cnt + 1;
		dev_cnt <= (rst_i || !sda_dev_oe) ? 0 : dev_cnt + 1;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_scl_held;
		scl ##1 scl;
	endsequence

	a_dev_open_drain: assert property (!sda_dev_o)
		else $error("target drives sda high");
	a_host_open_drain: assert property (!scl_host_o && !sda_host_o)
		else $error("host drives a line high");
	a_reset_idle: assert property ($fell(rst_i) |-> !sda_dev_oe && !scl_host_oe && !sda_host_oe)
		else $error("link not released after reset");
	a_dev_hold_high: assert property (s_scl_held |-> $stable(sda_dev_oe))
		else $error("target moved sda while scl high");
	a_cond_host_only: assert property (s_scl_held ##0 $changed(sda) |-> $changed(sda_host_oe))
		else $error("start or stop not made by host");
	a_scl_high_min: assert property ($fell(scl) |-> hi_cnt >= 240)
		else $error("scl high phase too short");
	a_scl_low_min: assert property ($rose(scl) |-> lo_cnt >= 240)
		else $error("scl low phase too short");
	a_dev_low_max: assert property (dev_cnt <= 9100)
		else $error("target holds sda low too long");
endmodule : smbus_link_assertions
`default_nettype wire

// [bench/clock_synth_smbus_control_tb.sv]
// Testbench joining host and target over the SMBus link
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_map.svh"
module clock_synth_smbus_control_tb;
	// Identity codes, arbitrary values
	localparam logic [3:0] REV = 4'h6;
	localparam logic [3:0] MKR = 4'h9;

	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_read_i  = 1'b0;
	logic [7:0]  cmd_index_i = 8'h00;
	logic [7:0]  cmd_count_i = 8'h00;
	logic [7:0]  wr_data_i   = 8'h00;
	logic        cmd_ready_o, wr_req_o, rd_valid_o, done_o, nack_o;
	logic [7:0]  rd_data_o, rd_len_o;
	logic        dsp_en, ref_en, spr_en, usb_en, prog_en;
	logic [1:0]  ns_en;
	logic [2:0]  srd_en;
	logic [4:0]  pci_en, margin;
	logic [3:0]  freq;
	logic [14:0] vco_mult;
	logic [6:0]  vco_div;
	logic [7:0]  wq [4];
	logic [1:0]  wr_ptr = 2'b00;
	logic [7:0]  rq [$];
	int          err_count = 0;
	int          checks = 0;
	int unsigned seed_v;

	always #5 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// Design under test
	// ----------------------------------------------------------------
	smbus_link_if smbus_link_if_inst ();

	smbus_target #(.REV_CODE(REV), .MAKER_CODE(MKR), .PART_CODE(8'h4e)) smbus_target_inst (
		.clk_i(clk_i), .rst_i(rst_i), .link(smbus_link_if_inst.device),
		.display_clock_96m_en_o(dsp_en), .nonspread_storage_clock_en_o(ns_en),
		.serdes_ref_clock_en_o(srd_en), .reference_14m_output_en_o(ref_en),
		.spread_en_o(spr_en), .pci_en_o(pci_en), .usb48_en_o(usb_en),
		.margin_sel_o(margin), .main_freq_sel_o(freq), .divider_prog_en_o(prog_en),
		.vco_mult_o(vco_mult), .vco_div_o(vco_div));

	smbus_host smbus_host_inst (
		.clk_i(clk_i), .rst_i(rst_i), .link(smbus_link_if_inst.host),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i),
		.cmd_index_i(cmd_index_i), .cmd_count_i(cmd_count_i), .wr_req_o(wr_req_o),
		.wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.rd_len_o(rd_len_o), .done_o(done_o), .nack_o(nack_o));

	smbus_link_assertions smbus_link_assertions_inst (
		.clk_i(clk_i), .rst_i(rst_i),
		.scl_host_o(smbus_link_if_inst.scl_host_o), .scl_host_oe(smbus_link_if_inst.scl_host_oe),
		.sda_host_o(smbus_link_if_inst.sda_host_o), .sda_host_oe(smbus_link_if_inst.sda_host_oe),
		.sda_dev_o(smbus_link_if_inst.sda_dev_o), .sda_dev_oe(smbus_link_if_inst.sda_dev_oe),
		.scl(smbus_link_if_inst.scl), .sda(smbus_link_if_inst.sda));

	// ----------------------------------------------------------------
	// Data feed and capture
	// ----------------------------------------------------------------
	// Next byte only after the pulse that consumed the current one
	always @(posedge clk_i) begin
		if (wr_req_o === 1'b1) begin
			wr_ptr <= wr_ptr + 2'd1;
			wr_data_i <= wq[wr_ptr + 2'd1];
		end
		if (rd_valid_o === 1'b1)
			rq.push_back(rd_data_o);
	end

	function automatic logic [14:0] exp_mult(input int n);
		return 15'(25 * (n + 8));
	endfunction : exp_mult

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic run_cmd(input logic rd, input logic [7:0] idx, input logic [7:0] cnt);
		int n;
		n = 0;
		cmd_valid_i <= 1'b1;
		cmd_read_i <= rd;
		cmd_index_i <= idx;
		cmd_count_i <= cnt;
		wr_data_i <= wq[0];
		wr_ptr <= 2'b00;
		@(posedge clk_i);
		while (cmd_ready_o !== 1'b1)
			@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		while (done_o !== 1'b1 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 40000)
			err_count++;
		@(posedge clk_i);
	endtask : run_cmd

	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		seed_v = $urandom(58935);
		wq[0] = 8'($urandom);
		wq[1] = 8'($urandom);
		wq[2] = 8'h02;
		wq[3] = 8'h00;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("enables", {4'h0, dsp_en, ns_en, srd_en, pci_en, usb_en}, 16'h0fff);
		check("ref spread", {14'h0, ref_en, spr_en}, 16'h0002);
		check("margin", {11'h0, margin}, 16'h000f);
		check("freq", {12'h0, freq}, 16'h0008);
		check("prog", {15'h0, prog_en}, 16'h0000);
		check("vco mult", {1'b0, vco_mult}, {1'b0, exp_mult(40)});
		check("vco div", {9'h0, vco_div}, 16'd12);
		// Block write over a read-only byte into the count register
		run_cmd(1'b0, 8'h06, 8'h03);
		check("freq written", {12'h0, freq}, {12'h0, wq[0][3:0]});
		check("margin kept", {11'h0, margin}, 16'h000f);
		check("data pulls", {14'h0, wr_ptr}, 16'h0003);
		check("write nack", {15'h0, nack_o}, 16'h0000);
		// Read back length now follows the count register
		run_cmd(1'b1, 8'h06, 8'h00);
		check("read len", {8'h0, rd_len_o}, 16'h0002);
		check("bytes read", 16'(rq.size()), 16'h0002);
		check("reg6 read", {8'h0, rq[0]}, {12'h0, wq[0][3:0]});
		check("reg7 read", {8'h0, rq[1]}, {8'h0, REV, MKR});
		check("read nack", {15'h0, nack_o}, 16'h0000);
		// Divider programming path with random M and N
		wq[0] = 8'h80;
		wq[1] = 8'($urandom);
		wq[2] = 8'($urandom);
		run_cmd(1'b0, 8'h0a, 8'h03);
		check("prog on", {15'h0, prog_en}, 16'h0001);
		check("vco mult prog", {1'b0, vco_mult},
			{1'b0, exp_mult({wq[1][6], wq[1][7], wq[2]})});
		check("vco div prog", {9'h0, vco_div}, {10'h0, wq[1][5:0]} + 16'd2);
		end_of_test();
	end

	initial begin
		repeat (95000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
endmodule : clock_synth_smbus_control_tb
`default_nettype wire
